// File: codec_ctrl_device.sv
// Purpose: Codec control: short protection, headset type, GPIO, interrupts, record and bypass paths.
// Assumes: Analog and pin inputs are asynchronous and are synchronised here.
// Notes: Page 0 holds control, page 1 holds filter coefficients.
// Contract
// - Shorted driver is current-clamped, enters protection.
// - Protection state readable at location 95.
// - Auto option powers down shorted drivers.
// - Auto-off driver stays off until power cycled.
// - Headset type readable at location 13.
// - AC-coupled mode cannot tell mono from stereo.
// - Host enables detect and auto-off via 38.
// - GPIO input level readable by register.
// - GPIO output drives programmed level.
// - GPIO may output clock or interrupt.
// - Interrupt sources routed alone or ORed.
// - Combined interrupts keep readable status register.
// - Interrupt is single pulse or pulse train.
// - Record-only reuses playback filter coefficients.
// - Host powers both DACs down first.
// - Host then sets record filter enable bit.
// - Filtered record path only while DACs off.
// - DAC current field resets lowest.
// - Bypass via 108 opens normal switches.
// - D0, D2 feed left positive output.
// - D1, D3 feed left negative output.
// - D4-D7 feed right outputs likewise.
// - Host avoids two switches per output.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module codec_ctrl_device
    import codec_ctrl_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    codec_link_if.device link,
    input wire logic [3:0] short_det,
    input wire logic [1:0] headset_type_in,
    input wire logic jack_in,
    input wire logic button_in,
    input wire logic agc_noise_in,
    input wire logic [1:0] int_clk,
    input wire logic [1:0] gpio_in,
    output logic [1:0] gpio_out,
    output logic [1:0] gpio_oe,
    output logic [3:0] current_limit,
    output logic [3:0] hp_driver_en,
    output logic dac_left_power,
    output logic dac_right_power,
    output logic [1:0] dac_current,
    output logic record_filter_reroute_switch,
    output logic left_pos_normal_switch,
    output logic left_pos_in1_pass_switch,
    output logic left_pos_in2_pass_switch,
    output logic left_neg_normal_switch,
    output logic left_neg_in1_pass_switch,
    output logic left_neg_in2_pass_switch,
    output logic right_pos_normal_switch,
    output logic right_pos_in1_pass_switch,
    output logic right_pos_in2_pass_switch,
    output logic right_neg_normal_switch,
    output logic right_neg_in1_pass_switch,
    output logic right_neg_in2_pass_switch
);
    localparam int SYNC_W = 11;
    logic [SYNC_W-1:0] async_in;
    logic [SYNC_W-1:0] sync_a;
    logic [SYNC_W-1:0] sync_b;
    logic [3:0] short_s;
    logic [1:0] headset_s;
    logic jack_s;
    logic button_s;
    logic agc_s;
    logic [1:0] gpio_s;
    logic page;
    logic [7:0] regs [0:255];
    logic take;
    logic [7:0] widx;
    logic writable;
    logic [7:0] next_rdata;
    logic irq_status_read;
    logic [3:0] live_short;
    logic [3:0] shut;
    logic [3:0] hp_power;
    logic [3:0] src;
    logic [3:0] src_q;
    logic [3:0] rise;
    logic [3:0] irq_status;
    logic [7:0] bypass;

    assign async_in = {gpio_in, agc_noise_in, button_in, jack_in, headset_type_in, short_det};
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= async_in;
            sync_b <= sync_a;
        end
    end
    assign short_s = sync_b[3:0];
    assign headset_s = sync_b[5:4];
    assign jack_s = sync_b[6];
    assign button_s = sync_b[7];
    assign agc_s = sync_b[8];
    assign gpio_s = sync_b[10:9];

    // Register access: taken when req is high and no ack is pending, answered one cycle later.
    assign take = link.req && !link.ack;
    assign widx = {page, link.addr};
    always_comb begin
        if (page) begin
            writable = (link.addr >= COEF_FIRST_ADDR) && (link.addr <= COEF_LAST_ADDR);
        end else begin
            case (link.addr)
                PAGE_CTRL_ADDR, SHORT_CIRCUIT_STATUS_ADDR, DETECT_STATUS_A_ADDR,
                DETECT_STATUS_B_ADDR, GPIO_LEVEL_ADDR, IRQ_STATUS_ADDR: writable = 1'b0;
                default: writable = 1'b1;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < 256; i++) begin
                regs[i] <= REG_RESET;
            end
        end else if (take && link.wr && writable) begin
            regs[widx] <= link.wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            page <= 1'b0;
        end else if (take && link.wr && link.addr == PAGE_CTRL_ADDR) begin
            page <= link.wdata[0];
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        if (link.addr == PAGE_CTRL_ADDR) begin
            next_rdata = {7'h00, page};
        end else if (page) begin
            if (writable) begin
                next_rdata = regs[widx];
            end
        end else begin
            case (link.addr)
                // Mono and stereo codes are unreliable while AC-coupled, so bit 2 flags that.
                HEADSET_DETECT_TYPE_ADDR: next_rdata = {regs[widx][7:3],
                    regs[{1'b0, OUTPUT_CONFIG_TYPE_ADDR}][OUTCFG_AC_COUPLED_BIT], headset_s};
                SHORT_CIRCUIT_STATUS_ADDR: next_rdata = {4'h0, live_short | shut};
                DETECT_STATUS_A_ADDR: next_rdata = {6'h00, button_s, jack_s};
                DETECT_STATUS_B_ADDR: next_rdata = {7'h00, agc_s};
                GPIO_LEVEL_ADDR: next_rdata = {6'h00, gpio_s};
                IRQ_STATUS_ADDR: next_rdata = {4'h0, irq_status};
                default: next_rdata = regs[widx];
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            link.ack <= 1'b0;
            link.rdata <= 8'h00;
        end else begin
            link.ack <= take;
            if (take && !link.wr) begin
                link.rdata <= next_rdata;
            end
        end
    end

    // Short-circuit protection. Clamping is always on; the config only governs shutdown.
    assign hp_power = regs[{1'b0, HP_DRIVER_POWER_ADDR}][NUM_DRIVERS-1:0];
    assign live_short = short_s & hp_power;
    assign current_limit = live_short;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            shut <= '0;
        end else begin
            // A power-down clears the latch and masks the short; a driver is released only by power-down then up.
            shut <= (shut & hp_power) | (live_short & {NUM_DRIVERS{
                regs[{1'b0, SHORT_PROTECT_CONFIG_ADDR}][SHORT_DETECT_EN_BIT] &&
                regs[{1'b0, SHORT_PROTECT_CONFIG_ADDR}][SHORT_AUTO_OFF_BIT]}});
        end
    end
    assign hp_driver_en = hp_power & ~shut;

    // Interrupt causes latch on rising edges; reading the status clears them.
    assign src[IRQ_JACK] = jack_s;
    assign src[IRQ_BUTTON] = button_s;
    assign src[IRQ_SHORT] = |live_short;
    assign src[IRQ_AGC_NOISE] = agc_s;
    assign irq_status_read = take && !link.wr && !page && link.addr == IRQ_STATUS_ADDR;
    assign rise = src & ~src_q;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            src_q <= '0;
            irq_status <= '0;
        end else begin
            src_q <= src;
            irq_status <= (irq_status & {NUM_IRQ_SRC{!irq_status_read}}) | rise;
        end
    end

    for (genvar g = 0; g < NUM_GPIO; g++) begin : gen_gpio
        logic [7:0] cfg;
        gpio_mode_t mode;
        logic [3:0] mask;
        logic [7:0] cnt;
        logic irq_level;
        logic next_out;
        assign cfg = regs[{1'b0, GPIO1_CTRL_ADDR + 7'(g)}];
        assign mode = gpio_mode_t'(cfg[GPIO_MODE_LSB +: 2]);
        assign mask = cfg[GPIO_MASK_LSB +: NUM_IRQ_SRC];
        always_ff @(posedge core_clk) begin
            if (rst) begin
                cnt <= 8'h00;
            end else if (mode != GPIO_IRQ) begin
                cnt <= 8'h00;
            end else if (cfg[GPIO_OPT_BIT]) begin
                // Pulse train repeats while any routed cause stays latched.
                if ((irq_status & mask) == 4'h0) begin
                    cnt <= 8'h00;
                end else if (cnt == 8'h00) begin
                    cnt <= 8'(IRQ_TRAIN_CYCLES);
                end else begin
                    cnt <= cnt - 8'h01;
                end
            end else if ((rise & mask) != 4'h0) begin
                cnt <= 8'(IRQ_PULSE_CYCLES);
            end else if (cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
            end
        end
        assign irq_level = cfg[GPIO_OPT_BIT] ? (cnt > 8'(IRQ_TRAIN_CYCLES - IRQ_PULSE_CYCLES)) : (cnt != 8'h00);
        always_comb begin
            case (mode)
                GPIO_OUTPUT: next_out = cfg[GPIO_OPT_BIT];
                GPIO_CLOCK: next_out = int_clk[cfg[GPIO_OPT_BIT]];
                GPIO_IRQ: next_out = irq_level;
                default: next_out = 1'b0;
            endcase
        end
        always_ff @(posedge core_clk) begin
            if (rst) begin
                gpio_out[g] <= 1'b0;
                gpio_oe[g] <= 1'b0;
            end else begin
                gpio_out[g] <= next_out;
                gpio_oe[g] <= mode != GPIO_INPUT;
            end
        end
    end

    // Record path and DAC controls.
    assign dac_left_power = regs[{1'b0, DAC_POWER_CONTROL_ADDR}][DAC_LEFT_POWER_BIT];
    assign dac_right_power = regs[{1'b0, DAC_POWER_CONTROL_ADDR}][DAC_RIGHT_POWER_BIT];
    assign record_filter_reroute_switch = regs[{1'b0, RECORD_PATH_CONFIG_ADDR}][RECORD_FILTER_EN_BIT]
        && !dac_left_power && !dac_right_power;
    assign dac_current = regs[{1'b0, DAC_CURRENT_SELECT_ADDR}][DAC_CURRENT_LSB +: 2];

    // Passive bypass; a closed pass switch opens the normal switch of its output.
    assign bypass = regs[{1'b0, PASSIVE_BYPASS_SWITCHES_ADDR}];
    assign left_pos_in1_pass_switch = bypass[0];
    assign left_pos_in2_pass_switch = bypass[2];
    assign left_pos_normal_switch = !(bypass[0] || bypass[2]);
    assign left_neg_in1_pass_switch = bypass[1];
    assign left_neg_in2_pass_switch = bypass[3];
    assign left_neg_normal_switch = !(bypass[1] || bypass[3]);
    assign right_pos_in1_pass_switch = bypass[4];
    assign right_pos_in2_pass_switch = bypass[6];
    assign right_pos_normal_switch = !(bypass[4] || bypass[6]);
    assign right_neg_in1_pass_switch = bypass[5];
    assign right_neg_in2_pass_switch = bypass[7];
    assign right_neg_normal_switch = !(bypass[5] || bypass[7]);
endmodule : codec_ctrl_device
`default_nettype wire

// File: codec_ctrl_host.sv
// Purpose: APB bridge issuing register accesses to the codec control logic.
// Assumes: Software writes a command word, then polls status for completion.
// Notes: Unsafe commands are refused here rather than forwarded.
`timescale 1ns/1ps
`default_nettype none
module codec_ctrl_host
    import codec_ctrl_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    codec_link_if.host link
);
    host_state_t state;
    logic access;
    logic cmd_wr;
    logic accept;
    logic unsafe;
    logic refused;
    logic page_shadow;
    logic [1:0] dac_shadow;
    logic [7:0] rdata;
    logic [6:0] c_addr;
    logic [7:0] c_data;

    assign access = psel && penable;
    assign pready = 1'b1;
    assign cmd_wr = access && pwrite && paddr == HOST_CMD_OFFSET;
    assign c_addr = pwdata[6:0];
    assign c_data = pwdata[CMD_WDATA_LSB +: 8];
    always_comb begin
        unsafe = 1'b0;
        if (pwdata[CMD_WRITE_BIT] && !page_shadow) begin
            if (c_addr == PASSIVE_BYPASS_SWITCHES_ADDR) begin
                unsafe = (c_data[0] && c_data[2]) || (c_data[1] && c_data[3]) ||
                         (c_data[4] && c_data[6]) || (c_data[5] && c_data[7]);
            end else if (c_addr == RECORD_PATH_CONFIG_ADDR) begin
                unsafe = c_data[RECORD_FILTER_EN_BIT] && (dac_shadow != 2'h0);
            end
        end
    end
    assign accept = cmd_wr && state == HOST_IDLE && !unsafe;
    assign pslverr = access && !(paddr == HOST_STATUS_OFFSET || (paddr == HOST_CMD_OFFSET && pwrite &&
        state == HOST_IDLE && !unsafe));
    assign prdata = (access && !pwrite && paddr == HOST_STATUS_OFFSET) ?
        {16'h0000, rdata, 6'h00, refused, state == HOST_REQ} : 32'h0000_0000;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= HOST_IDLE;
            link.req <= 1'b0;
            link.wr <= 1'b0;
            link.addr <= 7'h00;
            link.wdata <= 8'h00;
        end else begin
            case (state)
                HOST_IDLE: begin
                    if (accept) begin
                        state <= HOST_REQ;
                        link.req <= 1'b1;
                        link.wr <= pwdata[CMD_WRITE_BIT];
                        link.addr <= c_addr;
                        link.wdata <= c_data;
                    end
                end
                HOST_REQ: begin
                    if (link.ack) begin
                        state <= HOST_IDLE;
                        link.req <= 1'b0;
                    end
                end
                default: state <= HOST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            refused <= 1'b0;
        end else if (cmd_wr && state == HOST_IDLE) begin
            refused <= unsafe;
        end
    end

    // Shadows of page and DAC power let the bridge check the record-only entry order.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            page_shadow <= 1'b0;
            dac_shadow <= 2'h0;
        end else if (accept && pwdata[CMD_WRITE_BIT]) begin
            if (c_addr == PAGE_CTRL_ADDR) begin
                page_shadow <= c_data[0];
            end else if (!page_shadow && c_addr == DAC_POWER_CONTROL_ADDR) begin
                dac_shadow <= {c_data[DAC_LEFT_POWER_BIT], c_data[DAC_RIGHT_POWER_BIT]};
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (state == HOST_REQ && link.ack && !link.wr) begin
            rdata <= link.rdata;
        end
    end
endmodule : codec_ctrl_host
`default_nettype wire

// File: codec_ctrl_link_properties.sv
// Purpose: Protocol and readback checks on the codec register link.
// Assumes: One core_clk domain; rst is synchronous and active high.
// Notes: Shadows follow only writes that reach the link.
`timescale 1ns/1ps
`default_nettype none
module codec_ctrl_link_properties
    import codec_ctrl_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic req,
    input wire logic wr,
    input wire logic [6:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic ack
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    logic page;
    logic [7:0] cur;
    logic [7:0] byp;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            page <= 1'b0;
            cur <= 8'h00;
            byp <= 8'h00;
        end else if (ack && wr) begin
            if (addr == PAGE_CTRL_ADDR) page <= wdata[0];
            if (!page && addr == DAC_CURRENT_SELECT_ADDR) cur <= wdata;
            if (!page && addr == PASSIVE_BYPASS_SWITCHES_ADDR) byp <= wdata;
        end
    end
    AST_ACK_NEXT: assert property (req && !ack |=> ack) else $error("ack missing after request");
    AST_ACK_PULSE: assert property (ack |=> !ack) else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (ack |-> $past(req) && !$past(ack)) else $error("ack without request");
    AST_REQ_HOLD: assert property (req && !ack |=> req && $stable(addr) && $stable(wr) && $stable(wdata))
        else $error("request changed before ack");
    AST_REQ_DROP: assert property (ack |=> !req) else $error("request kept after ack");
    AST_RDATA_KEEP: assert property (!(ack && !wr) |-> $stable(rdata)) else $error("read data moved");
    AST_PAGE_READ: assert property (ack && !wr && addr == PAGE_CTRL_ADDR |-> rdata == {7'h00, page})
        else $error("page readback wrong");
    AST_CURRENT_READ: assert property (ack && !wr && !page && addr == DAC_CURRENT_SELECT_ADDR |->
        rdata[7:6] == cur[7:6]) else $error("current field readback wrong");
    AST_BYPASS_READ: assert property (ack && !wr && !page && addr == PASSIVE_BYPASS_SWITCHES_ADDR |->
        rdata == byp) else $error("bypass readback wrong");
endmodule : codec_ctrl_link_properties
`default_nettype wire

// File: codec_ctrl_pkg.sv
// Purpose: Shared constants for the codec control block and its host bridge.
// Assumes: One clock domain, core_clk at 250 MHz.
// Notes: Register addresses are 7-bit page-relative locations.
package codec_ctrl_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam logic [6:0] PAGE_CTRL_ADDR = 7'h00;
    localparam logic [6:0] HEADSET_DETECT_TYPE_ADDR = 7'h0D;
    localparam logic [6:0] OUTPUT_CONFIG_TYPE_ADDR = 7'h0E;
    localparam logic [6:0] DAC_POWER_CONTROL_ADDR = 7'h25;
    localparam logic [6:0] SHORT_PROTECT_CONFIG_ADDR = 7'h26;
    localparam logic [6:0] HP_DRIVER_POWER_ADDR = 7'h33;
    localparam logic [6:0] SHORT_CIRCUIT_STATUS_ADDR = 7'h5F;
    localparam logic [6:0] DETECT_STATUS_A_ADDR = 7'h60;
    localparam logic [6:0] DETECT_STATUS_B_ADDR = 7'h61;
    localparam logic [6:0] RECORD_PATH_CONFIG_ADDR = 7'h6B;
    localparam logic [6:0] PASSIVE_BYPASS_SWITCHES_ADDR = 7'h6C;
    localparam logic [6:0] DAC_CURRENT_SELECT_ADDR = 7'h6D;
    localparam logic [6:0] GPIO1_CTRL_ADDR = 7'h70;
    localparam logic [6:0] GPIO2_CTRL_ADDR = 7'h71;
    localparam logic [6:0] GPIO_LEVEL_ADDR = 7'h72;
    localparam logic [6:0] IRQ_STATUS_ADDR = 7'h73;
    localparam logic [6:0] COEF_FIRST_ADDR = 7'h01;
    localparam logic [6:0] COEF_LAST_ADDR = 7'h34;
    // Field positions.
    localparam int OUTCFG_AC_COUPLED_BIT = 0;
    localparam int DAC_LEFT_POWER_BIT = 7;
    localparam int DAC_RIGHT_POWER_BIT = 6;
    localparam int SHORT_DETECT_EN_BIT = 1;
    localparam int SHORT_AUTO_OFF_BIT = 2;
    localparam int RECORD_FILTER_EN_BIT = 3;
    localparam int DAC_CURRENT_LSB = 6;
    localparam int GPIO_MODE_LSB = 0;
    localparam int GPIO_OPT_BIT = 2;
    localparam int GPIO_MASK_LSB = 4;
    localparam int NUM_DRIVERS = 4;
    localparam int NUM_IRQ_SRC = 4;
    localparam int NUM_GPIO = 2;
    // Interrupt source order in masks and status.
    localparam int IRQ_JACK = 0;
    localparam int IRQ_BUTTON = 1;
    localparam int IRQ_SHORT = 2;
    localparam int IRQ_AGC_NOISE = 3;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [1:0] DAC_CURRENT_RESET = 2'h0;
    // Interrupt pulse timing.
    localparam int IRQ_PULSE_NS = 8;
    localparam int CLK_PERIOD_NS = 4;
    localparam int IRQ_PULSE_CYCLES = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IRQ_TRAIN_PERIOD_NS = 64;
    localparam int IRQ_TRAIN_CYCLES = IRQ_TRAIN_PERIOD_NS / CLK_PERIOD_NS;
    // Host bridge map.
    localparam logic [11:0] HOST_CMD_OFFSET = 12'h000;
    localparam logic [11:0] HOST_STATUS_OFFSET = 12'h004;
    localparam int CMD_WDATA_LSB = 8;
    localparam int CMD_WRITE_BIT = 7;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_REFUSED_BIT = 1;
    localparam int STAT_RDATA_LSB = 8;
    typedef enum logic [1:0] {GPIO_INPUT, GPIO_OUTPUT, GPIO_CLOCK, GPIO_IRQ} gpio_mode_t;
    typedef enum {HOST_IDLE, HOST_REQ} host_state_t;
endpackage : codec_ctrl_pkg

// File: codec_link_if.sv
// Purpose: Register link between host bridge and codec control logic.
// Assumes: Both ends run on the same core_clk.
// Notes: Request holds until ack; ack is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
interface codec_link_if;
    logic req;
    logic wr;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic ack;
    modport device (input req, input wr, input addr, input wdata, output rdata, output ack);
    modport host (output req, output wr, output addr, output wdata, input rdata, input ack);
endinterface : codec_link_if
`default_nettype wire

// File: codec_protect_irq_mode_ctrl_test.sv
// Purpose: Self-checking bench for the APB bridge and codec control logic.
// Assumes: core_clk at 250 MHz.
// Notes: A monitor checks link reads against queued expectations.
`timescale 1ns/1ps
`default_nettype none
module codec_protect_irq_mode_ctrl_test
    import codec_ctrl_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] short_det = 4'h0;
    logic [1:0] headset_type_in = 2'h0;
    logic jack_in = 1'b0, button_in = 1'b0, agc_noise_in = 1'b0;
    logic [1:0] int_clk = 2'h0, gpio_in = 2'h0;
    wire [31:0] prdata;
    wire pready, pslverr, dl, dr, rec_sw;
    wire [1:0] gpio_out, gpio_oe, dac_current;
    wire [3:0] current_limit, hp_driver_en;
    wire [11:0] sw;
    int n_fail = 0, n_tests = 0;
    logic [15:0] exp_q[$], note;
    codec_link_if link();
    codec_ctrl_host i_codec_ctrl_host(.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .link(link));
    codec_ctrl_device i_codec_ctrl_device(.core_clk, .rst, .link(link), .short_det, .headset_type_in, .jack_in,
        .button_in, .agc_noise_in, .int_clk, .gpio_in, .gpio_out, .gpio_oe, .current_limit, .hp_driver_en,
        .dac_left_power(dl), .dac_right_power(dr), .dac_current, .record_filter_reroute_switch(rec_sw),
        .left_pos_normal_switch(sw[11]),
        .left_pos_in1_pass_switch(sw[10]), .left_pos_in2_pass_switch(sw[9]), .left_neg_normal_switch(sw[8]),
        .left_neg_in1_pass_switch(sw[7]), .left_neg_in2_pass_switch(sw[6]), .right_pos_normal_switch(sw[5]),
        .right_pos_in1_pass_switch(sw[4]), .right_pos_in2_pass_switch(sw[3]), .right_neg_normal_switch(sw[2]),
        .right_neg_in1_pass_switch(sw[1]), .right_neg_in2_pass_switch(sw[0]));
    codec_ctrl_link_properties i_codec_ctrl_link_properties(.core_clk, .rst, .req(link.req),
        .wr(link.wr), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack));
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) int_clk <= int_clk + 2'h1;
    task automatic tally_and_finish();
        if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic chk_read(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t read %h expected %h", $time, got, exp);
        end
    endtask : chk_read
    task automatic chk_port(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t port %h expected %h", $time, got, exp);
        end
    endtask : chk_port
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [32:0] r);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        r = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic link_op(input logic [6:0] a, input logic w, input logic [7:0] d, output logic [1:0] rf);
        logic [32:0] s;
        apb(HOST_CMD_OFFSET, 1'b1, {16'h0000, d, w, a}, s);
        rf[1] = s[32];
        do apb(HOST_STATUS_OFFSET, 1'b0, 32'h0, s); while (s[STAT_BUSY_BIT] !== 1'b0);
        rf[0] = s[STAT_REFUSED_BIT];
    endtask : link_op
    task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic rf_exp);
        logic [1:0] rf;
        link_op(a, 1'b1, d, rf);
        chk_port({14'h0, rf}, {14'h0, rf_exp, rf_exp});
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [7:0] m, input logic [7:0] x);
        logic [1:0] rf;
        exp_q.push_back({m, x & m});
        link_op(a, 1'b0, 8'h00, rf);
    endtask : rd
    task automatic cnt(input int idx, input int n, output int k);
        k = 0;
        repeat (n) begin
            @(negedge core_clk);
            k += (gpio_out[idx] === 1'b1) ? 1 : 0;
        end
    endtask : cnt
    always @(posedge core_clk) begin
        if (!rst && link.ack === 1'b1 && link.wr === 1'b0) begin
            note = exp_q.pop_front();
            chk_read(link.rdata & note[15:8], note[7:0]);
        end
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        tally_and_finish();
    end
    initial begin
        logic [7:0] v, c;
        logic [11:0] e;
        logic [1:0] g;
        int s, b, k;
        void'($urandom(32'hB0AE));
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        rd(DAC_CURRENT_SELECT_ADDR, 8'hC0, 8'h00);
        chk_port({14'h0, dac_current}, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            v = 8'h00;
            e = 12'h000;
            for (int j = 0; j < 4; j++) begin
                s = $urandom % 3;
                b = (j & 1) | ((j >> 1) << 2);
                if (s == 1) v[b] = 1'b1;
                if (s == 2) v[b + 2] = 1'b1;
                e = {e[8:0], ~(v[b] | v[b + 2]), v[b], v[b + 2]};
            end
            wr(PASSIVE_BYPASS_SWITCHES_ADDR, v, 1'b0);
            @(negedge core_clk);
            chk_port({4'h0, sw}, {4'h0, e});
        end
        wr(PASSIVE_BYPASS_SWITCHES_ADDR, 8'h05, 1'b1);
        rd(PASSIVE_BYPASS_SWITCHES_ADDR, 8'hFF, v);
        wr(DAC_POWER_CONTROL_ADDR, 8'hC0, 1'b0);
        wr(RECORD_PATH_CONFIG_ADDR, 8'h08, 1'b1);
        wr(DAC_POWER_CONTROL_ADDR, 8'h00, 1'b0);
        wr(RECORD_PATH_CONFIG_ADDR, 8'h08, 1'b0);
        @(negedge core_clk);
        chk_port({15'h0, rec_sw}, 16'h0001);
        wr(DAC_POWER_CONTROL_ADDR, 8'h40, 1'b0);
        @(negedge core_clk);
        chk_port({13'h0, dl, dr, rec_sw}, 16'h0002);
        wr(PAGE_CTRL_ADDR, 8'h01, 1'b0);
        rd(PAGE_CTRL_ADDR, 8'hFF, 8'h01);
        c = 8'($urandom);
        wr(COEF_LAST_ADDR, c, 1'b0);
        wr(7'h35, 8'hA5, 1'b0);
        rd(COEF_LAST_ADDR, 8'hFF, c);
        rd(7'h35, 8'hFF, 8'h00);
        wr(PAGE_CTRL_ADDR, 8'h00, 1'b0);
        wr(HP_DRIVER_POWER_ADDR, 8'h0F, 1'b0);
        wr(SHORT_PROTECT_CONFIG_ADDR, 8'h06, 1'b0);
        short_det <= 4'h1;
        repeat (6) @(posedge core_clk);
        rd(SHORT_CIRCUIT_STATUS_ADDR, 8'h0F, 8'h01);
        chk_port({8'h0, current_limit, hp_driver_en}, 16'h001E);
        short_det <= 4'h0;
        repeat (6) @(posedge core_clk);
        rd(SHORT_CIRCUIT_STATUS_ADDR, 8'h0F, 8'h01);
        rd(IRQ_STATUS_ADDR, 8'h04, 8'h04);
        wr(HP_DRIVER_POWER_ADDR, 8'h0E, 1'b0);
        wr(HP_DRIVER_POWER_ADDR, 8'h0F, 1'b0);
        rd(SHORT_CIRCUIT_STATUS_ADDR, 8'h0F, 8'h00);
        chk_port({12'h0, hp_driver_en}, 16'h000F);
        headset_type_in <= 2'h2;
        wr(OUTPUT_CONFIG_TYPE_ADDR, 8'h01, 1'b0);
        rd(HEADSET_DETECT_TYPE_ADDR, 8'h07, 8'h06);
        g = 2'($urandom);
        gpio_in <= g;
        wr(GPIO1_CTRL_ADDR, 8'h00, 1'b0);
        rd(GPIO_LEVEL_ADDR, 8'h03, {6'h00, g});
        wr(GPIO1_CTRL_ADDR, {5'h00, g[1], 2'h1}, 1'b0);
        @(negedge core_clk);
        chk_port({13'h0, gpio_oe, gpio_out[0]}, {13'h0, 2'h1, g[1]});
        wr(GPIO1_CTRL_ADDR, 8'h02, 1'b0);
        cnt(0, 20, k);
        chk_port(16'(k), 16'h000A);
        wr(GPIO2_CTRL_ADDR, 8'hF3, 1'b0);
        {agc_noise_in, button_in} <= 2'h3;
        cnt(1, 40, k);
        chk_port(16'(k), 16'(IRQ_PULSE_CYCLES));
        rd(IRQ_STATUS_ADDR, 8'h0F, 8'h0A);
        wr(GPIO2_CTRL_ADDR, 8'h17, 1'b0);
        jack_in <= 1'b1;
        cnt(1, 60, k);
        chk_port(16'(k >= 6), 16'h0001);
        rd(IRQ_STATUS_ADDR, 8'h0F, 8'h01);
        cnt(1, 40, k);
        chk_port(16'(k), 16'h0000);
        tally_and_finish();
    end
endmodule : codec_protect_irq_mode_ctrl_test
`default_nettype wire
